// ### inc/exec_consts.svh
// numeric constants of the 8-bit execution unit: offsets, flag bits, clock counts
// assumes a 32-bit register bus with byte addresses, one register per word
// Functional notes
// - add two registers, carry optional, store sum, update Z C N V H, one clock
// - subtract register or constant, carry optional, update Z C N V H, one clock
// - AND, OR, XOR update Z N V S only, carry untouched, one clock
// - set bits ORs constant, clear bits ANDs inverse constant, Z N V S only
// - zero or minus test ANDs register with itself, value unchanged, one clock
// - call jumps to pc plus offset plus one in three clocks; return four
// - compare skip equal skips next instruction, no flags, one or two clocks
// - compares subtract without storing, update Z N V C H, one clock
// - skip on register bit cleared or set, no flags, one or two clocks
// - skip on I/O register bit cleared or set, one or two clocks
// - status branches test chosen flag, jump pc plus offset plus one
// - equal, not equal test Z; carry branches test C; minus, plus test N
// - same or higher branches on carry zero, lower on carry one
// - signed greater or equal when N xor V zero, less when one
// - further branches test half carry, transfer bit and overflow flags
// - interrupts enabled branch when I is one, disabled when zero
// - indirect load and store address memory by pointer, two clocks, no flags
// - register copy and load immediate in one clock, flags unchanged
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// register offsets, byte addresses
`define OFF_INSTR   8'h00
`define OFF_PC      8'h04
`define OFF_FLAGS   8'h08
`define OFF_CTRL    8'h0C
`define OFF_RIDX    8'h10
`define OFF_RDATA   8'h14
`define OFF_CYC     8'h18
`define MEM_SEL_BIT 8
`define CTRL_LONG   0

// status register bit positions
`define FL_C 3'd0
`define FL_Z 3'd1
`define FL_N 3'd2
`define FL_V 3'd3
`define FL_S 3'd4
`define FL_H 3'd5
`define FL_T 3'd6
`define FL_I 3'd7

`define FLAGS_RST 8'h00
`define PTR_REG   5'd30

// clocks per instruction
`define CLK_ONE    3'd1
`define CLK_JUMP   3'd2
`define CLK_CALL   3'd3
`define CLK_RETURN 3'd4
`define CLK_SKIP   3'd2
`define CLK_TAKEN  3'd2
`define CLK_XFER   3'd2

`endif

// ### inc/exec_pkg.sv
// types of the 8-bit execution unit
// assumes exec_consts.svh supplies all numeric constants
package exec_pkg;

	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUB_IMM, OP_SUB_CARRY,
		OP_SUB_IMM_CARRY, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR,
		OP_SET_BITS, OP_CLEAR_BITS, OP_ZERO_TEST, OP_REL_JUMP, OP_REL_CALL,
		OP_SUB_RETURN, OP_INT_RETURN, OP_CMP_SKIP_EQ, OP_COMPARE, OP_CMP_CARRY,
		OP_CMP_IMM, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR,
		OP_SKIP_IO_SET, OP_BRANCH_SET, OP_BRANCH_CLR, OP_IND_LOAD,
		OP_IND_STORE, OP_REG_COPY, OP_LOAD_IMM
	} op_e;

	typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS} alu_e;

	typedef enum logic [1:0] {S_IDLE, S_EXEC, S_HOLD} state_e;

	// instruction word layout, bit 30 down to 0
	typedef struct packed {
		logic [5:0]  op;
		logic [2:0]  bitSel;
		logic [4:0]  rd;
		logic [4:0]  rr;
		logic [11:0] k;
	} instr_s;

	typedef struct packed {
		logic [7:0] value;
		logic [7:0] flags;
	} alu_res_s;

endpackage

// ### design/alu_unit.sv
// 8-bit arithmetic and logic unit with status flag generation
// assumes the caller decides whether result and flags are stored
`timescale 1ns/1ps
`include "exec_consts.svh"

module alu_unit
	import exec_pkg::*;
(
	input  wire alu_e       fn,
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  wire logic       zChain,
	input  wire logic [7:0] flagsIn,
	output alu_res_s        res
);

	logic [7:0] r;
	logic [7:0] f;
	logic [7:0] ax;
	logic [7:0] bx;
	logic [7:0] rn;
	logic [7:0] cy;
	logic       isSub;
	logic       isArith;
	logic       ovf;

	// result of the selected operation
	always_comb begin
		case (fn)
			ALU_ADD: r = a + b + {7'h00, cin};
			ALU_SUB: r = a - b - {7'h00, cin};
			ALU_AND: r = a & b;
			ALU_OR:  r = a | b;
			ALU_XOR: r = a ^ b;
			default: r = b;
		endcase
	end

	// carry terms per bit; subtraction inverts a and the result sense
	assign isSub   = (fn == ALU_SUB);
	assign isArith = (fn == ALU_ADD) || isSub;
	assign ax      = isSub ? ~a : a;
	assign bx      = isSub ? ~b : b;
	assign rn      = isSub ? r : ~r;
	assign cy      = (ax & b) | (b & rn) | (rn & ax);
	assign ovf     = (a[7] & bx[7] & ~r[7]) | (~a[7] & ~bx[7] & r[7]);

	// flag update; logic ops clear V and keep C and H
	always_comb begin
		f = flagsIn;
		if (fn != ALU_PASS) begin
			f[`FL_Z] = (r == 8'h00) && (!zChain || flagsIn[`FL_Z]);
			f[`FL_N] = r[7];
			f[`FL_V] = isArith ? ovf : 1'b0;
			f[`FL_S] = r[7] ^ f[`FL_V];
			if (isArith) begin
				f[`FL_C] = cy[7];
				f[`FL_H] = cy[3];
			end
		end
	end

	assign res = '{value: r, flags: f};

endmodule

// ### design/exec_core.sv
// execution unit of an 8-bit core: working registers, status flags,
// program counter, return stack and data memory behind an Avalon-MM slave
// assumes one clock and a master that holds each request until waitrequest drops
`timescale 1ns/1ps
`include "exec_consts.svh"

module exec_core
	import exec_pkg::*;
#(
	parameter int PC_WIDTH    = 9,
	parameter int STACK_DEPTH = 4,
	parameter int DMEM_DEPTH  = 64
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [8:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic      [5:0]  ioAddr,
	input  wire logic [7:0]  ioData,
	output logic             busy
);

	localparam int SPW = $clog2(STACK_DEPTH);
	localparam int DAW = $clog2(DMEM_DEPTH);

	typedef logic [PC_WIDTH-1:0] pc_t;

	localparam pc_t            PC_ONE = pc_t'(1);
	localparam pc_t            PC_TWO = pc_t'(2);
	localparam logic [SPW-1:0] SP_ONE = SPW'(1);

	// refuse sizes the decode cannot serve
	if (PC_WIDTH < 8 || PC_WIDTH > 16) begin : g_bad_pc
		$error("PC_WIDTH must lie in 8..16");
	end
	if (STACK_DEPTH < 2 || STACK_DEPTH != (1 << SPW)) begin : g_bad_stack
		$error("STACK_DEPTH must be a power of two, at least 2");
	end
	if (DMEM_DEPTH < 4 || DMEM_DEPTH > 64 || DMEM_DEPTH != (1 << DAW)) begin : g_bad_mem
		$error("DMEM_DEPTH must be a power of two in 4..64");
	end

	// state
	state_e         state_q;
	state_e         state_d;
	logic [2:0]     cnt_q;
	logic [2:0]     cnt_d;
	instr_s         instr_q;
	logic [7:0]     flags_q;
	logic [7:0]     flags_d;
	pc_t            pc_q;
	pc_t            pc_d;
	logic [SPW-1:0] sp_q;
	logic [SPW-1:0] sp_d;
	logic [4:0]     regIdx_q;
	logic           longNext_q;
	logic [31:0]    cycles_q;
	logic [31:0]    readdata_q;
	logic           waitReq_q;
	logic           waitReq_d;
	logic [5:0]     ioAddr_q;
	logic           busy_q;

	// storage without reset
	logic [7:0] gpr_q   [32];
	logic [7:0] dmem_q  [DMEM_DEPTH];
	pc_t        stack_q [STACK_DEPTH];

	// bus decode
	logic        acc;
	logic        accWr;
	logic        accRd;
	logic        startExec;
	logic        selMem;
	logic        selInstr;
	logic        selPc;
	logic        selFlags;
	logic        selCtrl;
	logic        selIdx;
	logic        selData;
	logic        selCyc;
	logic [31:0] rdMux;

	// a request is taken only while idle and not in its answer cycle
	assign acc       = (read || write) && waitReq_q && (state_q == S_IDLE);
	assign accWr     = acc && write;
	assign accRd     = acc && read;
	assign selMem    = address[`MEM_SEL_BIT];
	assign selInstr  = !selMem && (address[7:0] == `OFF_INSTR);
	assign selPc     = !selMem && (address[7:0] == `OFF_PC);
	assign selFlags  = !selMem && (address[7:0] == `OFF_FLAGS);
	assign selCtrl   = !selMem && (address[7:0] == `OFF_CTRL);
	assign selIdx    = !selMem && (address[7:0] == `OFF_RIDX);
	assign selData   = !selMem && (address[7:0] == `OFF_RDATA);
	assign selCyc    = !selMem && (address[7:0] == `OFF_CYC);
	assign startExec = accWr && selInstr;

	// read data selection, unmapped reads return zero
	assign rdMux = selMem   ? {24'h000000, dmem_q[address[2 +: DAW]]} :
	               selInstr ? {1'b0, instr_q} :
	               selPc    ? {{(32 - PC_WIDTH){1'b0}}, pc_q} :
	               selFlags ? {24'h000000, flags_q} :
	               selCtrl  ? {31'h00000000, longNext_q} :
	               selIdx   ? {27'h0000000, regIdx_q} :
	               selData  ? {24'h000000, gpr_q[regIdx_q]} :
	               selCyc   ? cycles_q : 32'h00000000;

	// operand fetch
	op_e        op;
	logic       execNow;
	logic [7:0] opA;
	logic [7:0] opB;
	logic [7:0] imm;
	logic [7:0] ptr;
	logic [7:0] memRd;
	logic [2:0] sel;

	assign op      = op_e'(instr_q.op);
	assign execNow = (state_q == S_EXEC);
	assign opA     = gpr_q[instr_q.rd];
	assign opB     = gpr_q[instr_q.rr];
	assign imm     = instr_q.k[7:0];
	assign ptr     = gpr_q[`PTR_REG];
	assign memRd   = dmem_q[ptr[DAW-1:0]];
	assign sel     = instr_q.bitSel;

	// alu control
	alu_e       fn;
	logic [7:0] aluB;
	logic       useC;
	logic       zChain;
	logic       wbEn;
	alu_res_s   aluRes;

	always_comb begin
		fn     = ALU_PASS;
		aluB   = opB;
		useC   = 1'b0;
		zChain = 1'b0;
		wbEn   = 1'b0;
		case (op)
			OP_ADD: begin
				fn   = ALU_ADD;
				wbEn = 1'b1;
			end
			OP_ADD_CARRY: begin
				fn   = ALU_ADD;
				useC = 1'b1;
				wbEn = 1'b1;
			end
			OP_SUBTRACT: begin
				fn   = ALU_SUB;
				wbEn = 1'b1;
			end
			OP_SUB_IMM: begin
				fn   = ALU_SUB;
				aluB = imm;
				wbEn = 1'b1;
			end
			OP_SUB_CARRY: begin
				fn     = ALU_SUB;
				useC   = 1'b1;
				zChain = 1'b1;
				wbEn   = 1'b1;
			end
			OP_SUB_IMM_CARRY: begin
				fn     = ALU_SUB;
				aluB   = imm;
				useC   = 1'b1;
				zChain = 1'b1;
				wbEn   = 1'b1;
			end
			OP_AND: begin
				fn   = ALU_AND;
				wbEn = 1'b1;
			end
			OP_AND_IMM: begin
				fn   = ALU_AND;
				aluB = imm;
				wbEn = 1'b1;
			end
			OP_OR: begin
				fn   = ALU_OR;
				wbEn = 1'b1;
			end
			OP_OR_IMM, OP_SET_BITS: begin
				fn   = ALU_OR;
				aluB = imm;
				wbEn = 1'b1;
			end
			OP_XOR: begin
				fn   = ALU_XOR;
				wbEn = 1'b1;
			end
			OP_CLEAR_BITS: begin
				fn   = ALU_AND;
				aluB = ~imm;
				wbEn = 1'b1;
			end
			OP_ZERO_TEST: begin
				fn   = ALU_AND;
				aluB = opA;
			end
			OP_COMPARE: begin
				fn = ALU_SUB;
			end
			OP_CMP_CARRY: begin
				fn     = ALU_SUB;
				useC   = 1'b1;
				zChain = 1'b1;
			end
			OP_CMP_IMM: begin
				fn   = ALU_SUB;
				aluB = imm;
			end
			OP_REG_COPY: begin
				wbEn = 1'b1;
			end
			OP_LOAD_IMM: begin
				aluB = imm;
				wbEn = 1'b1;
			end
			OP_IND_LOAD: begin
				aluB = memRd;
				wbEn = 1'b1;
			end
			default: begin
				fn = ALU_PASS;
			end
		endcase
	end

	alu_unit u_alu (
		.fn      (fn),
		.a       (opA),
		.b       (aluB),
		.cin     (useC && flags_q[`FL_C]),
		.zChain  (zChain),
		.flagsIn (flags_q),
		.res     (aluRes)
	);

	// branch and skip conditions; named branches pick their flag by bitSel
	logic flagBit;
	logic takeBr;
	logic doSkip;
	logic isCall;
	logic isRet;

	assign flagBit = (sel == `FL_S) ? (flags_q[`FL_N] ^ flags_q[`FL_V]) : flags_q[sel];
	assign takeBr  = ((op == OP_BRANCH_SET) && flagBit)
	              || ((op == OP_BRANCH_CLR) && !flagBit);
	assign doSkip  = ((op == OP_CMP_SKIP_EQ) && (opA == opB))
	              || ((op == OP_SKIP_REG_CLR) && !opB[sel])
	              || ((op == OP_SKIP_REG_SET) && opB[sel])
	              || ((op == OP_SKIP_IO_CLR) && !ioData[sel])
	              || ((op == OP_SKIP_IO_SET) && ioData[sel]);
	assign isCall  = (op == OP_REL_CALL);
	assign isRet   = (op == OP_SUB_RETURN) || (op == OP_INT_RETURN);

	// next program counter
	logic [15:0]    kExt;
	pc_t            pcInc;
	pc_t            pcRel;
	pc_t            pcSkip;
	pc_t            pcNext;
	logic [SPW-1:0] spDec;

	assign kExt   = {{4{instr_q.k[11]}}, instr_q.k};
	assign pcInc  = pc_q + PC_ONE;
	assign pcRel  = pcInc + kExt[PC_WIDTH-1:0];
	assign pcSkip = pcInc + (longNext_q ? PC_TWO : PC_ONE);
	assign spDec  = sp_q - SP_ONE;
	assign pcNext = ((op == OP_REL_JUMP) || isCall || takeBr) ? pcRel :
	                isRet  ? stack_q[spDec] :
	                doSkip ? pcSkip : pcInc;

	// clocks each instruction occupies
	logic [2:0] clocks;

	always_comb begin
		case (op)
			OP_REL_JUMP:                 clocks = `CLK_JUMP;
			OP_REL_CALL:                 clocks = `CLK_CALL;
			OP_SUB_RETURN, OP_INT_RETURN: clocks = `CLK_RETURN;
			OP_IND_LOAD, OP_IND_STORE:   clocks = `CLK_XFER;
			OP_BRANCH_SET, OP_BRANCH_CLR: clocks = takeBr ? `CLK_TAKEN : `CLK_ONE;
			default:                     clocks = doSkip ? `CLK_SKIP : `CLK_ONE;
		endcase
	end

	// sequencing: the first exec cycle commits, hold cycles only wait
	logic execDone;

	assign execDone = (execNow && (clocks == `CLK_ONE)) || ((state_q == S_HOLD) && (cnt_q == 3'h0));

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			S_IDLE: begin
				if (startExec) begin
					state_d = S_EXEC;
				end
			end
			S_EXEC: begin
				cnt_d   = clocks - 3'h2;
				state_d = (clocks == `CLK_ONE) ? S_IDLE : S_HOLD;
			end
			S_HOLD: begin
				cnt_d   = cnt_q - 3'h1;
				state_d = (cnt_q == 3'h0) ? S_IDLE : S_HOLD;
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	// flags: alu result, interrupt return also enables interrupts
	always_comb begin
		flags_d = flags_q;
		if (execNow) begin
			flags_d = aluRes.flags;
			if (op == OP_INT_RETURN) begin
				flags_d[`FL_I] = 1'b1;
			end
		end else if (accWr && selFlags) begin
			flags_d = writedata[7:0];
		end
	end

	assign pc_d      = execNow ? pcNext : (accWr && selPc) ? writedata[PC_WIDTH-1:0] : pc_q;
	assign sp_d      = (execNow && isCall) ? sp_q + SP_ONE : (execNow && isRet) ? spDec : sp_q;
	assign waitReq_d = !((acc && !startExec) || execDone);

	// control state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q   <= S_IDLE;
			cnt_q     <= 3'h0;
			flags_q   <= `FLAGS_RST;
			pc_q      <= '0;
			sp_q      <= '0;
			waitReq_q <= 1'b1;
			busy_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			flags_q   <= flags_d;
			pc_q      <= pc_d;
			sp_q      <= sp_d;
			waitReq_q <= waitReq_d;
			busy_q    <= (state_d != S_IDLE);
		end
	end

	// software-visible registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr_q    <= '0;
			ioAddr_q   <= 6'h00;
			regIdx_q   <= 5'h00;
			longNext_q <= 1'b0;
			cycles_q   <= 32'h00000000;
			readdata_q <= 32'h00000000;
		end else begin
			if (startExec) begin
				instr_q  <= writedata[30:0];
				ioAddr_q <= writedata[5:0];
			end
			if (accWr && selIdx) begin
				regIdx_q <= writedata[4:0];
			end
			if (accWr && selCtrl) begin
				longNext_q <= writedata[`CTRL_LONG];
			end
			if (state_q != S_IDLE) begin
				cycles_q <= cycles_q + 32'h00000001;
			end
			if (accRd) begin
				readdata_q <= rdMux;
			end
		end
	end

	// storage write ports; bus and execution never collide
	logic           gprWe;
	logic [4:0]     gprWa;
	logic [7:0]     gprWd;
	logic           memWe;
	logic [DAW-1:0] memWa;
	logic [7:0]     memWd;

	assign gprWe = (execNow && wbEn) || (accWr && selData);
	assign gprWa = execNow ? instr_q.rd : regIdx_q;
	assign gprWd = execNow ? aluRes.value : writedata[7:0];
	assign memWe = (execNow && (op == OP_IND_STORE)) || (accWr && selMem);
	assign memWa = execNow ? ptr[DAW-1:0] : address[2 +: DAW];
	assign memWd = execNow ? opB : writedata[7:0];

	always_ff @(posedge clk) begin
		if (gprWe) begin
			gpr_q[gprWa] <= gprWd;
		end
		if (memWe) begin
			dmem_q[memWa] <= memWd;
		end
		if (execNow && isCall) begin
			stack_q[sp_q] <= pcInc;
		end
	end

	assign readdata    = readdata_q;
	assign waitrequest = waitReq_q;
	assign ioAddr      = ioAddr_q;
	assign busy        = busy_q;

	// checks
	default clocking cbk @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [8:0] sum9;
	logic       isLogic;

	assign sum9    = {1'b0, opA} + {1'b0, opB};
	assign isLogic = (op == OP_AND) || (op == OP_OR) || (op == OP_XOR) || (op == OP_AND_IMM)
	              || (op == OP_OR_IMM) || (op == OP_SET_BITS) || (op == OP_CLEAR_BITS)
	              || (op == OP_ZERO_TEST);

	sequence s_last_hold;
		(state_q == S_HOLD) ##1 (state_q == S_IDLE && !waitReq_q);
	endsequence

	property p_add_flags;
		execNow && (op == OP_ADD) |=> flags_q[`FL_C] == $past(sum9[8])
			&& flags_q[`FL_Z] == ($past(sum9[7:0]) == 8'h00);
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

	property p_sub_borrow;
		execNow && (op == OP_SUBTRACT) |=> flags_q[`FL_C] == $past(opA < opB);
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");

	property p_logic_keep;
		execNow && isLogic |=> $stable(flags_q[`FL_C]) && !flags_q[`FL_V];
	endproperty
	a_logic_keep: assert property (p_logic_keep) else $error("logic op touched C or V");

	property p_call_three;
		execNow && isCall |=> (state_q == S_HOLD) ##1 s_last_hold
			##0 (pc_q == $past(pcRel, 3));
	endproperty
	a_call_three: assert property (p_call_three) else $error("call timing wrong");

	property p_return_four;
		execNow && isRet |=> (state_q == S_HOLD) [*2] ##1 s_last_hold;
	endproperty
	a_return_four: assert property (p_return_four) else $error("return timing wrong");

	property p_skip_equal;
		execNow && (op == OP_CMP_SKIP_EQ) && (opA == opB)
			|=> (pc_q == $past(pcSkip)) && $stable(flags_q) && (state_q == S_HOLD);
	endproperty
	a_skip_equal: assert property (p_skip_equal) else $error("equal skip wrong");

	property p_io_skip;
		execNow && (op == OP_SKIP_IO_SET) && ioData[sel] |=> pc_q == $past(pcSkip);
	endproperty
	a_io_skip: assert property (p_io_skip) else $error("io skip missed");

	property p_branch_not_taken;
		execNow && (op == OP_BRANCH_SET || op == OP_BRANCH_CLR) && !takeBr
			|=> (state_q == S_IDLE) && (pc_q == $past(pcInc));
	endproperty
	a_branch_not_taken: assert property (p_branch_not_taken) else $error("untaken branch wrong");

	property p_signed_ge;
		execNow && (op == OP_BRANCH_CLR) && (sel == `FL_S)
			|-> takeBr == !(flags_q[`FL_N] ^ flags_q[`FL_V]);
	endproperty
	a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong");

	property p_xfer_two;
		execNow && (op == OP_IND_LOAD || op == OP_IND_STORE) |=> $stable(flags_q) ##0 s_last_hold;
	endproperty
	a_xfer_two: assert property (p_xfer_two) else $error("transfer timing wrong");

	property p_copy_one;
		execNow && (op == OP_REG_COPY || op == OP_LOAD_IMM) |=> $stable(flags_q) && (state_q == S_IDLE);
	endproperty
	a_copy_one: assert property (p_copy_one) else $error("copy changed flags");

	property p_jump_two;
		execNow && (op == OP_REL_JUMP) |=> (pc_q == $past(pcRel)) ##0 s_last_hold;
	endproperty
	a_jump_two: assert property (p_jump_two) else $error("jump wrong");

	property p_int_return;
		execNow && (op == OP_INT_RETURN) |=> flags_q[`FL_I];
	endproperty
	a_int_return: assert property (p_int_return) else $error("interrupt return left I clear");

endmodule

// ### testbench/tb_risc8_arith_branch_transfer_exec.sv
// bench for exec_core: one instruction per table row, then branches, calls, memory
// assumes the design answers each request by dropping waitrequest for one cycle
`timescale 1ns/1ps
`include "exec_consts.svh"

module tb_risc8_arith_branch_transfer_exec
	import exec_pkg::*;
;
	typedef struct packed {
		op_e        op;
		logic [2:0] bs;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] fi;
		logic [7:0] ev;
		logic [7:0] ef;
		logic [7:0] pc;
		logic [2:0] nc;
	} row_s;

	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [8:0]  address = 9'h000;
	logic        read = 1'h0;
	logic        write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [7:0]  ioData = 8'h00;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [5:0]  ioAddr;
	logic        busy;
	logic [31:0] rdat;
	logic [7:0]  fl;
	logic        tk;
	int          nclk;
	int          nErrors = 0;
	int          cmpCount = 0;

	// op, bit, rd value, rr value and constant, flags in, result, flags, pc, clocks
	row_s rows[31] = '{
		'{OP_NOP,3'h0,8'h33,8'h44,8'h0F,8'h33,8'h0F,8'h11,3'h1},
		'{OP_ADD,3'h0,8'h0F,8'h01,8'h01,8'h10,8'h20,8'h11,3'h1},
		'{OP_ADD,3'h0,8'h80,8'h80,8'h00,8'h00,8'h0B,8'h11,3'h1},
		'{OP_ADD_CARRY,3'h0,8'h7F,8'h00,8'h01,8'h80,8'h2C,8'h11,3'h1},
		'{OP_SUBTRACT,3'h0,8'h10,8'h01,8'h00,8'h0F,8'h20,8'h11,3'h1},
		'{OP_SUB_IMM,3'h0,8'h00,8'h01,8'h00,8'hFF,8'h25,8'h11,3'h1},
		'{OP_SUB_CARRY,3'h0,8'h05,8'h04,8'h03,8'h00,8'h02,8'h11,3'h1},
		'{OP_SUB_CARRY,3'h0,8'h05,8'h04,8'h01,8'h00,8'h00,8'h11,3'h1},
		'{OP_SUB_IMM_CARRY,3'h0,8'h80,8'h01,8'h00,8'h7F,8'h28,8'h11,3'h1},
		'{OP_AND,3'h0,8'hF0,8'h8F,8'h29,8'h80,8'h25,8'h11,3'h1},
		'{OP_AND_IMM,3'h0,8'h0F,8'hF0,8'h00,8'h00,8'h02,8'h11,3'h1},
		'{OP_OR,3'h0,8'h01,8'h80,8'h01,8'h81,8'h05,8'h11,3'h1},
		'{OP_OR_IMM,3'h0,8'h00,8'h00,8'h00,8'h00,8'h02,8'h11,3'h1},
		'{OP_XOR,3'h0,8'hFF,8'hFF,8'h08,8'h00,8'h02,8'h11,3'h1},
		'{OP_SET_BITS,3'h0,8'h10,8'h01,8'h00,8'h11,8'h00,8'h11,3'h1},
		'{OP_CLEAR_BITS,3'h0,8'hFF,8'h0F,8'h01,8'hF0,8'h05,8'h11,3'h1},
		'{OP_ZERO_TEST,3'h0,8'h80,8'h00,8'h08,8'h80,8'h04,8'h11,3'h1},
		'{OP_COMPARE,3'h0,8'h10,8'h20,8'h00,8'h10,8'h05,8'h11,3'h1},
		'{OP_CMP_CARRY,3'h0,8'h20,8'h20,8'h01,8'h20,8'h25,8'h11,3'h1},
		'{OP_CMP_IMM,3'h0,8'h42,8'h42,8'h00,8'h42,8'h02,8'h11,3'h1},
		'{OP_REG_COPY,3'h0,8'h11,8'h5A,8'hFF,8'h5A,8'hFF,8'h11,3'h1},
		'{OP_LOAD_IMM,3'h0,8'h11,8'hA5,8'h3C,8'hA5,8'h3C,8'h11,3'h1},
		'{OP_REL_JUMP,3'h0,8'h33,8'hFA,8'h0F,8'h33,8'h0F,8'h0B,3'h2},
		'{OP_CMP_SKIP_EQ,3'h0,8'h42,8'h42,8'h27,8'h42,8'h27,8'h12,3'h2},
		'{OP_CMP_SKIP_EQ,3'h0,8'h42,8'h43,8'h00,8'h42,8'h00,8'h11,3'h1},
		'{OP_SKIP_REG_SET,3'h3,8'h08,8'h08,8'h00,8'h08,8'h00,8'h12,3'h2},
		'{OP_SKIP_REG_CLR,3'h3,8'h08,8'h08,8'h00,8'h08,8'h00,8'h11,3'h1},
		'{OP_SKIP_REG_CLR,3'h2,8'h08,8'h08,8'h00,8'h08,8'h00,8'h12,3'h2},
		'{OP_SKIP_IO_CLR,3'h0,8'h01,8'h01,8'h00,8'h01,8'h00,8'h11,3'h1},
		'{OP_SKIP_IO_CLR,3'h1,8'h01,8'h01,8'h00,8'h01,8'h00,8'h12,3'h2},
		'{OP_SKIP_IO_SET,3'h0,8'h01,8'h01,8'h00,8'h01,8'h00,8'h12,3'h2}
	};
	logic [8:0]  offs[6] = '{9'h000, 9'h004, 9'h008, 9'h00C, 9'h018, 9'h01C};

	// free running clock
	always #50 clk = ~clk;

	// design under test with default sizes
	exec_core exec_core_i (
		.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.ioAddr(ioAddr), .ioData(ioData), .busy(busy)
	);

	// verdict and end of run
	task automatic finishTest();
		$display("comparisons %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one transfer, held until waitrequest is sampled low; nclk counts edges
	task automatic bus(logic wr, logic [8:0] adr, logic [31:0] wd);
		@(posedge clk);
		address <= adr;
		write <= wr;
		read <= !wr;
		writedata <= wd;
		nclk = 0;
		do begin
			@(posedge clk);
			nclk++;
			if (wr && adr == 9'h000 && nclk == 2) begin
				check("busy", 32'h1, 32'(busy));
			end
		end while (waitrequest !== 1'h0 && nclk < 60);
		rdat = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (waitrequest !== 1'h0) begin
			check("answer", 32'h0, 32'(waitrequest));
			finishTest();
		end
	endtask

	task automatic expectReg(string what, logic [8:0] adr, logic [31:0] exp);
		bus(1'h0, adr, 32'h0);
		check(what, exp, rdat);
	endtask

	task automatic setReg(logic [4:0] idx, logic [7:0] v);
		bus(1'h1, `OFF_RIDX, 32'(idx));
		bus(1'h1, `OFF_RDATA, 32'(v));
	endtask

	// instruction on rd 16 and rr 17; nclk minus two is its clock count
	task automatic exec(op_e op, logic [2:0] bs, logic [11:0] k);
		instr_s ins;
		ins = '{op: op, bitSel: bs, rd: 5'h10, rr: 5'h11, k: k};
		bus(1'h1, `OFF_INSTR, {1'h0, ins});
	endtask

	task automatic runRow(row_s r);
		setReg(5'h10, r.a);
		setReg(5'h11, r.b);
		bus(1'h1, `OFF_FLAGS, 32'(r.fi));
		bus(1'h1, `OFF_PC, 32'h10);
		ioData <= r.a;
		exec(r.op, r.bs, 12'(signed'(r.b)));
		check("clocks", 32'(r.nc), 32'(nclk - 2));
		check("ioAddr", 32'(r.b[5:0]), 32'(ioAddr));
		expectReg("pc", `OFF_PC, 32'(r.pc));
		bus(1'h0, `OFF_FLAGS, 32'h0);
		check("flags", 32'(r.ef & 8'hEF), rdat & 32'hEF);
		bus(1'h1, `OFF_RIDX, 32'h10);
		expectReg("result", `OFF_RDATA, 32'(r.ev));
	endtask

	// reset, table, then branches, long skip, call and return, memory
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		check("busy", 32'h0, 32'(busy));
		check("ioAddr", 32'h0, 32'(ioAddr));
		bus(1'h1, 9'h018, 32'h55);
		bus(1'h1, 9'h01C, 32'h55);
		foreach (offs[i]) begin
			expectReg("reset value", offs[i], 32'h0);
		end
		foreach (rows[i]) begin
			runRow(rows[i]);
		end
		for (int s = 0; s < 8; s++) begin
			for (int m = 0; m < 4; m++) begin
				fl = m[0] ? ((s == 4) ? 8'h04 : 8'h01 << s) : ~(8'h01 << s);
				tk = m[0] ^ m[1]; // bit 1 of m picks the cleared variant
				bus(1'h1, `OFF_FLAGS, 32'(fl));
				bus(1'h1, `OFF_PC, 32'h40);
				exec(m[1] ? OP_BRANCH_CLR : OP_BRANCH_SET, 3'(s), 12'h005);
				check("branch clocks", tk ? 32'h2 : 32'h1, 32'(nclk - 2));
				expectReg("branch pc", `OFF_PC, tk ? 32'h46 : 32'h41);
				expectReg("branch flags", `OFF_FLAGS, 32'(fl));
			end
		end
		bus(1'h1, `OFF_CTRL, 32'h1);
		bus(1'h1, `OFF_PC, 32'h10);
		exec(OP_CMP_SKIP_EQ, 3'h0, 12'h000);
		check("long skip clocks", 32'h2, 32'(nclk - 2));
		expectReg("long skip pc", `OFF_PC, 32'h13);
		bus(1'h1, `OFF_CTRL, 32'h0);
		for (int v = 0; v < 2; v++) begin
			bus(1'h1, `OFF_FLAGS, 32'h0);
			bus(1'h1, `OFF_PC, 32'h20);
			exec(OP_REL_CALL, 3'h0, 12'h010);
			check("call clocks", 32'h3, 32'(nclk - 2));
			expectReg("call pc", `OFF_PC, 32'h31);
			exec(v ? OP_INT_RETURN : OP_SUB_RETURN, 3'h0, 12'h000);
			check("return clocks", 32'h4, 32'(nclk - 2));
			expectReg("return pc", `OFF_PC, 32'h21);
			expectReg("return flags", `OFF_FLAGS, v ? 32'h80 : 32'h0);
		end
		setReg(`PTR_REG, 8'h05);
		setReg(5'h11, 8'h3C);
		exec(OP_IND_STORE, 3'h0, 12'h000);
		check("store clocks", 32'h2, 32'(nclk - 2));
		expectReg("stored byte", 9'h114, 32'h3C);
		bus(1'h1, 9'h118, 32'hC3);
		setReg(`PTR_REG, 8'h06);
		exec(OP_IND_LOAD, 3'h0, 12'h000);
		check("load clocks", 32'h2, 32'(nclk - 2));
		bus(1'h1, `OFF_RIDX, 32'h10);
		expectReg("loaded byte", `OFF_RDATA, 32'hC3);
		expectReg("transfer flags", `OFF_FLAGS, 32'h80);
		finishTest();
	end
endmodule
